// [core/cmd_word_buffer.sv]
// Two-entry word buffer with valid/ready on both sides.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module cmd_word_buffer
  import stepper_cmd_pkg::*;
#(
  parameter int WIDTH = WORD_W,   // Word width
  parameter int DEPTH = BUF_DEPTH // Entries, power of two
) (
  input  wire logic             i_clk,     // System clock
  input  wire logic             i_rst,     // Sync reset
  input  wire logic             i_ce,      // Clock enable
  input  wire logic             i_flush,   // Drop all entries
  input  wire logic             i_valid,   // Write request
  input  wire logic [WIDTH-1:0] i_data,    // Write data
  output logic                  o_ready,   // Room for a word
  output logic                  o_valid,   // Word available
  output logic      [WIDTH-1:0] o_data,    // Head word, registered
  input  wire logic             i_ready    // Reader takes head
);
  localparam int AW = $clog2(DEPTH);       // Pointer width

  // ============================================================
  // Storage and pointers
  // ============================================================
  logic [WIDTH-1:0] mem_reg [DEPTH];       // Entry storage
  logic [AW-1:0]    wr_ptr_reg;            // Next write slot
  logic [AW-1:0]    rd_ptr_reg;            // Current head slot
  logic [AW:0]      count_reg;             // Words held
  wire              push = i_valid && o_ready;  // Write accepted
  wire              pop  = o_valid && i_ready;  // Read accepted
  wire  [AW:0]      count_next = count_reg + (AW+1)'(push)
                                 - (AW+1)'(pop);
  wire  [AW-1:0]    rd_ptr_next = rd_ptr_reg + AW'(pop);

  // Entry writes; no reset needed on data storage
  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem_reg[wr_ptr_reg] <= i_data;
    end
  end

  // Pointers, count and registered flags
  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && i_flush)) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      o_ready    <= 1'b1;
      o_valid    <= 1'b0;
    end else if (i_ce) begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      o_ready    <= (count_next != (AW+1)'(DEPTH)); // Honest full
      o_valid    <= (count_next != '0);             // Honest empty
    end
  end

  // Head word out of a register; bypass when writing to empty
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_data <= '0;
    end else if (i_ce) begin
      if (push && (count_reg == '0 || (count_reg == 1 && pop))) begin
        o_data <= i_data;
      end else if (pop) begin
        o_data <= mem_reg[rd_ptr_next];
      end
    end
  end
endmodule // cmd_word_buffer

// [core/stepper_cmd_reg.sv]
// Serial command register of a two-coil stepper driver: shift
// register, storage register, cascade output, blanking, clear,
// sleep and latched fault flags.
// Assumes every serial pin is asynchronous to i_clk and that the
// serial clock is at least four system clocks high and low.
`timescale 1ns/1ps

// Functional notes
// - Word: A dir, A on, B dir, B on, torque
// - Rising serial clock shifts data in; the code skips the shift while blanking is high
// - Falling serial clock drives last stage out
// - Latch rising edge copies shift to storage
// - Latch falling edge changes nothing
// - Blanking high forces all controls low
// - Blanking low lets storage drive outputs
// - Clear low empties both registers
// - Torque codes 1000..1111 give 52..100 percent
// - Torque codes 0000..0111 give 0..43 percent
// - Drive-on bit low turns coil outputs off
// - Direction bit sets coil current polarity
// - Sleep low stops oscillator, outputs, logic
// - Sleep high resumes normal operation
// - Sleep low releases both fault flags
module stepper_cmd_reg
  import stepper_cmd_pkg::*;
(
  input  wire logic               i_clk,              // 40 MHz clock
  input  wire logic               i_rst,              // Sync reset
  input  wire logic               i_ce,               // Clock enable
  input  wire logic               i_serial_clk,       // Serial clock pin
  input  wire logic               i_serial_data,      // Serial data pin
  input  wire logic               i_latch,            // Latch strobe pin
  input  wire logic               i_blank,            // Blanking pin
  input  wire logic               i_register_clear_n, // Clear, low
  input  wire logic               i_sleep_n,          // Sleep, low
  input  wire logic               i_fault_open,       // Load open pin
  input  wire logic               i_fault_overcur,    // Overcurrent pin
  input  wire logic               i_fault_thermal,    // Overheat pin
  input  wire logic               i_cmd_ready,        // Stage takes word
  output logic                    o_last_shift_stage, // Cascade out
  output logic                    o_coil_a_direction, // A polarity
  output logic                    o_coil_a_drive_on,  // A stage on
  output logic                    o_coil_b_direction, // B polarity
  output logic                    o_coil_b_drive_on,  // B stage on
  output logic [TRQ_W-1:0]        o_torque_code,      // Bit1 is MSB
  output logic [RATIO_W-1:0]      o_coil_current,     // Ratio percent
  output logic                    o_coil_a_pos,       // A+ high side
  output logic                    o_coil_a_neg,       // A- high side
  output logic                    o_coil_b_pos,       // B+ high side
  output logic                    o_coil_b_neg,       // B- high side
  output logic                    o_chop_oscillator,  // Chopper run
  output logic                    o_error_flag1,      // Flag 1 level
  output logic                    o_error_flag1_oe,   // Flag 1 pull low
  output logic                    o_error_flag2,      // Flag 2 level
  output logic                    o_error_flag2_oe,   // Flag 2 pull low
  output logic                    o_cmd_valid,        // Word waiting
  output logic [WORD_W-1:0]       o_cmd_data,         // Latched word
  output logic                    o_cmd_room,         // Buffer has room
  output logic                    o_latch_overrun     // Word overwritten
);

  // ============================================================
  // Pin synchronisers
  // ============================================================
  localparam int NPIN = 9;                 // Synchronised pins
  logic [NPIN-1:0] pin_meta_reg;           // First stage, raw
  logic [NPIN-1:0] pin_sync_reg;           // Second stage, safe
  logic            sclk_prev_reg;          // Last synced serial clk
  logic            latch_prev_reg;         // Last synced latch
  wire  [NPIN-1:0] pin_raw = {i_fault_thermal, i_fault_overcur,
                              i_fault_open, i_sleep_n,
                              i_register_clear_n, i_blank,
                              i_latch, i_serial_data,
                              i_serial_clk};

  // Two flops per pin; stage one read only by stage two
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else if (i_ce) begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ============================================================
  // Named synchronised levels and edges
  // ============================================================
  wire sclk     = pin_sync_reg[0];         // Serial clock level
  wire sdata    = pin_sync_reg[1];         // Serial data level
  wire latch    = pin_sync_reg[2];         // Latch level
  wire blank    = pin_sync_reg[3];         // Blanking level
  wire clear_n  = pin_sync_reg[4];         // Clear level, low
  wire sleep_n  = pin_sync_reg[5];         // Sleep level, low
  wire f_open   = pin_sync_reg[6];         // Load open fault
  wire f_ovc    = pin_sync_reg[7];         // Overcurrent fault
  wire f_hot    = pin_sync_reg[8];         // Thermal fault

  wire sclk_rise  = sclk && !sclk_prev_reg;   // Serial clock up
  wire sclk_fall  = !sclk && sclk_prev_reg;   // Serial clock down
  wire latch_rise = latch && !latch_prev_reg; // Latch up edge
  // Latch falling edge has no effect, so it is not decoded

  // Logic held in its initial state while asleep or cleared
  wire logic_init = !sleep_n;
  wire regs_init  = logic_init || !clear_n;

  // Edge history; cleared together with the synchronisers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sclk_prev_reg  <= 1'b0;
      latch_prev_reg <= 1'b0;
    end else if (i_ce) begin
      sclk_prev_reg  <= sclk;
      latch_prev_reg <= latch;
    end
  end

  // ============================================================
  // Shift register and storage register
  // ============================================================
  logic [WORD_W-1:0] shift_reg;            // Serial shift stages
  logic [WORD_W-1:0] store_reg;            // Storage register
  logic              cascade_reg;          // Cascade pin driver

  // First stage takes data, others move up by one
  wire shift_en = sclk_rise && !blank;
  wire [WORD_W-1:0] shift_next =
    {shift_reg[WORD_W-2:0], sdata};

  // Shift register: clear is a level, not an edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shift_reg <= WORD_CLEAR;
    end else if (i_ce) begin
      if (regs_init) begin
        shift_reg <= WORD_CLEAR;
      end else if (shift_en) begin
        shift_reg <= shift_next;
      end
    end
  end

  // Storage copies on the latch edge, ignoring clock and data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      store_reg <= WORD_CLEAR;
    end else if (i_ce) begin
      if (regs_init) begin
        store_reg <= WORD_CLEAR;
      end else if (latch_rise) begin
        store_reg <= shift_reg;
      end
    end
  end

  // Cascade output loads data only on the falling serial clock,
  // giving the next device a half period of setup and hold
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cascade_reg <= 1'b0;
    end else if (i_ce) begin
      if (regs_init) begin
        cascade_reg <= 1'b0;
      end else if (sclk_fall) begin
        cascade_reg <= shift_reg[WORD_W-1];
      end
    end
  end

  // ============================================================
  // Control decode
  // ============================================================
  // Blanking or sleep forces every control low
  wire pass = !blank && sleep_n;
  wire [WORD_W-1:0] ctl = pass ? store_reg : WORD_CLEAR;

  wire a_dir = ctl[BIT_A_DIR];
  wire a_on  = ctl[BIT_A_ON];
  wire b_dir = ctl[BIT_B_DIR];
  wire b_on  = ctl[BIT_B_ON];
  wire [TRQ_W-1:0] trq = {ctl[BIT_TORQUE_BIT1], ctl[BIT_TORQUE_BIT2],
                          ctl[BIT_TORQUE_BIT3], ctl[BIT_TORQUE_BIT4]};

  // Bridge legs: off coil drives neither side, high impedance
  wire a_pos = a_on && a_dir;
  wire a_neg = a_on && !a_dir;
  wire b_pos = b_on && b_dir;
  wire b_neg = b_on && !b_dir;

  // Registered controls; outputs come straight from flops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_coil_a_direction <= 1'b0;
      o_coil_a_drive_on  <= 1'b0;
      o_coil_b_direction <= 1'b0;
      o_coil_b_drive_on  <= 1'b0;
      o_torque_code      <= '0;
      o_coil_current     <= '0;
    end else if (i_ce) begin
      o_coil_a_direction <= a_dir;
      o_coil_a_drive_on  <= a_on;
      o_coil_b_direction <= b_dir;
      o_coil_b_drive_on  <= b_on;
      o_torque_code      <= trq;
      o_coil_current     <= torque_ratio(trq);
    end
  end

  // Bridge leg drives, also flop outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_coil_a_pos <= 1'b0;
      o_coil_a_neg <= 1'b0;
      o_coil_b_pos <= 1'b0;
      o_coil_b_neg <= 1'b0;
    end else if (i_ce) begin
      o_coil_a_pos <= a_pos;
      o_coil_a_neg <= a_neg;
      o_coil_b_pos <= b_pos;
      o_coil_b_neg <= b_neg;
    end
  end

  // ============================================================
  // Chopper enable and cascade pin
  // ============================================================
  // Oscillator runs only while awake
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_chop_oscillator  <= 1'b0;
      o_last_shift_stage <= 1'b0;
    end else if (i_ce) begin
      o_chop_oscillator  <= sleep_n;
      o_last_shift_stage <= cascade_reg;
    end
  end

  // ============================================================
  // Latched fault flags, open drain
  // ============================================================
  // Encoding: open -> flag2; overcurrent -> flag1; thermal -> both
  logic err_open_reg;                      // Load open latched
  logic err_ovc_reg;                       // Overcurrent latched
  logic err_hot_reg;                       // Thermal latched

  // Faults stick until sleep; only sleep or reset releases them
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      err_open_reg <= 1'b0;
      err_ovc_reg  <= 1'b0;
      err_hot_reg  <= 1'b0;
    end else if (i_ce) begin
      if (logic_init) begin
        err_open_reg <= 1'b0;
        err_ovc_reg  <= 1'b0;
        err_hot_reg  <= 1'b0;
      end else begin
        err_open_reg <= err_open_reg || f_open;
        err_ovc_reg  <= err_ovc_reg || f_ovc;
        err_hot_reg  <= err_hot_reg || f_hot;
      end
    end
  end

  // Thermal outranks overcurrent, which outranks open load
  wire flag1_low = err_hot_reg || err_ovc_reg;
  wire flag2_low = err_hot_reg || (err_open_reg && !err_ovc_reg);

  // Pin drivers: enable high means pulling the line low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_error_flag1    <= 1'b0;
      o_error_flag1_oe <= 1'b0;
      o_error_flag2    <= 1'b0;
      o_error_flag2_oe <= 1'b0;
    end else if (i_ce) begin
      o_error_flag1    <= 1'b0;
      o_error_flag1_oe <= flag1_low;
      o_error_flag2    <= 1'b0;
      o_error_flag2_oe <= flag2_low;
    end
  end

  // ============================================================
  // Latched word stream toward the output stage
  // ============================================================
  // A word waits here while the buffer is full, so a stall by the
  // reader loses nothing unless a further latch arrives meanwhile
  logic              pend_valid_reg;       // Word waiting to enter
  logic [WORD_W-1:0] pend_word_reg;        // That word
  logic              buf_ready;            // Buffer room, registered
  wire               pend_take = pend_valid_reg && buf_ready;

  // Capture each latched word; flag an overwrite
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_valid_reg  <= 1'b0;
      pend_word_reg   <= WORD_CLEAR;
      o_latch_overrun <= 1'b0;
    end else if (i_ce) begin
      if (regs_init) begin
        pend_valid_reg  <= 1'b0;
        o_latch_overrun <= 1'b0;
      end else if (latch_rise) begin
        pend_valid_reg  <= 1'b1;
        pend_word_reg   <= shift_reg;
        o_latch_overrun <= pend_valid_reg && !buf_ready;
      end else if (pend_take) begin
        pend_valid_reg  <= 1'b0;
        o_latch_overrun <= 1'b0;
      end
    end
  end

  // Buffer room reported as a flop
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cmd_room <= 1'b1;
    end else if (i_ce) begin
      o_cmd_room <= buf_ready;
    end
  end

  // Two-entry buffer; flushed by clear or sleep
  cmd_word_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_flush (regs_init),
    .i_valid (pend_valid_reg),
    .i_data  (pend_word_reg),
    .o_ready (buf_ready),
    .o_valid (o_cmd_valid),
    .o_data  (o_cmd_data),
    .i_ready (i_cmd_ready)
  );

endmodule // stepper_cmd_reg

// [pkg/stepper_cmd_pkg.sv]
// Shared constants for the serial command register of a two-coil
// stepper driver. Assumes one 40 MHz system clock.
package stepper_cmd_pkg;

  // ============================================================
  // Command word layout
  // ============================================================
  localparam int WORD_W      = 8;   // Bits per command word
  localparam int BIT_A_DIR   = 0;   // Coil A direction
  localparam int BIT_A_ON    = 1;   // Coil A drive on
  localparam int BIT_B_DIR   = 2;   // Coil B direction
  localparam int BIT_B_ON    = 3;   // Coil B drive on
  localparam int BIT_TORQUE_BIT1    = 4;   // Torque bit 1 (code MSB)
  localparam int BIT_TORQUE_BIT2    = 5;   // Torque bit 2
  localparam int BIT_TORQUE_BIT3    = 6;   // Torque bit 3
  localparam int BIT_TORQUE_BIT4    = 7;   // Torque bit 4 (code LSB)
  localparam int TRQ_W       = 4;   // Torque code width
  localparam int RATIO_W     = 7;   // Percent field width

  // ============================================================
  // Reset values and buffering
  // ============================================================
  localparam logic [WORD_W-1:0] WORD_CLEAR = 8'h00; // Cleared word
  localparam int BUF_DEPTH   = 2;   // Entries in output buffer

  // ============================================================
  // Torque code to current ratio in percent
  // ============================================================
  function automatic logic [RATIO_W-1:0] torque_ratio(
    input logic [TRQ_W-1:0] code
  );
    case (code)
      4'hF:    torque_ratio = 7'h64; // 100
      4'hE:    torque_ratio = 7'h5E; // 94
      4'hD:    torque_ratio = 7'h56; // 86
      4'hC:    torque_ratio = 7'h50; // 80
      4'hB:    torque_ratio = 7'h4A; // 74
      4'hA:    torque_ratio = 7'h43; // 67
      4'h9:    torque_ratio = 7'h3C; // 60
      4'h8:    torque_ratio = 7'h34; // 52
      4'h7:    torque_ratio = 7'h2B; // 43
      4'h6:    torque_ratio = 7'h26; // 38
      4'h5:    torque_ratio = 7'h1D; // 29
      4'h4:    torque_ratio = 7'h19; // 25
      4'h3:    torque_ratio = 7'h0F; // 15
      4'h2:    torque_ratio = 7'h0A; // 10
      4'h1:    torque_ratio = 7'h05; // 5
      default: torque_ratio = 7'h00; // 0
    endcase
  endfunction

endpackage

// [verif/host_serial_model.sv]
// Host serial port model: serial clock, serial data, latch strobe.
// Assumes the caller waits for each task to return before the next.
`timescale 1ns/1ps
module host_serial_model (
  input  wire logic i_clk,                // System clock
  output logic      o_serial_clk  = 1'b0, // Serial clock, idle low
  output logic      o_serial_data = 1'b0, // Serial data
  output logic      o_latch       = 1'b0  // Latch strobe
);
  // ============================================================
  // Frame tasks
  // ============================================================
  // First bit sent lands in bit 7; clock period is eight cycles
  task automatic send_word(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk) o_serial_data <= w[i];
      repeat (2) @(posedge i_clk);
      o_serial_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_serial_clk <= 1'b0;
      @(posedge i_clk);
    end
    // Released line shows the inverse, never the stale bit
    o_serial_data <= ~w[0];
  endtask
  // Strobe held four cycles; gap lets the last shift settle
  task automatic pulse_latch();
    repeat (3) @(posedge i_clk);
    o_latch <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_latch <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
endmodule // host_serial_model

// [verif/stepper_cmd_reg_checker.sv]
// Concurrent checks on the stepper command register ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module stepper_cmd_reg_checker
  import stepper_cmd_pkg::*;
(
  input wire logic               i_clk,              // System clock
  input wire logic               i_rst,              // Sync reset
  input wire logic               i_ce,               // Clock enable
  input wire logic               i_latch,            // Latch strobe
  input wire logic               i_blank,            // Blanking
  input wire logic               i_register_clear_n, // Clear, low
  input wire logic               i_sleep_n,          // Sleep, low
  input wire logic               o_coil_a_direction, // A polarity
  input wire logic               o_coil_a_drive_on,  // A stage on
  input wire logic               o_coil_b_direction, // B polarity
  input wire logic               o_coil_b_drive_on,  // B stage on
  input wire logic [TRQ_W-1:0]   o_torque_code,      // Torque code
  input wire logic [RATIO_W-1:0] o_coil_current,     // Percent
  input wire logic               o_coil_a_pos,       // A+ leg
  input wire logic               o_coil_a_neg,       // A- leg
  input wire logic               o_coil_b_pos,       // B+ leg
  input wire logic               o_coil_b_neg,       // B- leg
  input wire logic               o_chop_oscillator,  // Chopper run
  input wire logic               o_error_flag1_oe,   // Flag 1 drive
  input wire logic               o_error_flag2_oe,   // Flag 2 drive
  input wire logic               o_cmd_valid,        // Word waiting
  input wire logic               o_last_shift_stage  // Cascade out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // All eight controls; windows allow for the pin synchronisers
  wire logic [7:0] ctl = {o_coil_a_direction, o_coil_a_drive_on,
    o_coil_b_direction, o_coil_b_drive_on, o_torque_code};
  sequence s_awake;
    i_ce && i_register_clear_n && i_sleep_n;
  endsequence
  sequence s_latch;
    $rose(i_latch) ##0 s_awake [*4];
  endsequence
  // ============================================================
  // Assertions
  // ============================================================
  chk_blank_forces_low: assert property (
    i_blank [*6] |-> ctl == 8'h00) else $error("controls not blanked");
  chk_clear_empties: assert property (
    (!i_register_clear_n) [*6] |-> ctl == 8'h00 && !o_last_shift_stage
    && !o_cmd_valid) else $error("clear left state behind");
  chk_sleep_all_off: assert property (
    (!i_sleep_n) [*6] |-> !o_chop_oscillator && !o_error_flag1_oe
    && !o_error_flag2_oe && ctl == 8'h00) else $error("sleep left on");
  chk_wake_resumes: assert property (
    i_sleep_n [*8] |-> o_chop_oscillator) else $error("no wake");
  chk_legs_a: assert property (
    o_coil_a_pos == (o_coil_a_drive_on && o_coil_a_direction)
    && o_coil_a_neg == (o_coil_a_drive_on && !o_coil_a_direction))
    else $error("coil A legs wrong");
  chk_legs_b: assert property (
    o_coil_b_pos == (o_coil_b_drive_on && o_coil_b_direction)
    && o_coil_b_neg == (o_coil_b_drive_on && !o_coil_b_direction))
    else $error("coil B legs wrong");
  chk_ratio_full: assert property (
    o_torque_code == 4'hF |-> o_coil_current == 7'h64)
    else $error("full ratio wrong");
  chk_ratio_low: assert property (
    o_torque_code == 4'h7 |-> o_coil_current == 7'h2B)
    else $error("low ratio wrong");
  chk_controls_hold: assert property (
    (!i_latch && !i_blank && i_register_clear_n && i_sleep_n) [*8]
    |=> $stable(ctl)) else $error("controls moved without latch");
  chk_latch_word: assert property (
    s_latch |-> ##[1:3] o_cmd_valid) else $error("latched word lost");
endmodule // stepper_cmd_reg_checker

bind stepper_cmd_reg stepper_cmd_reg_checker stepper_cmd_reg_checker_i (.*);

// [verif/stepper_cmd_reg_tb.sv]
// Self-checking bench for the stepper serial command register.
// Assumes the host model drives the serial pins and latch.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module stepper_cmd_reg_tb;
  import stepper_cmd_pkg::*;
  // ============================================================
  // Signals and expectations
  // ============================================================
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_blank = 0, i_cmd_ready = 1;
  logic i_register_clear_n = 1, i_sleep_n = 1;
  logic i_fault_open = 0, i_fault_overcur = 0, i_fault_thermal = 0;
  wire logic i_serial_clk, i_serial_data, i_latch;
  logic o_last_shift_stage, o_coil_a_direction, o_coil_a_drive_on;
  logic o_coil_b_direction, o_coil_b_drive_on, o_chop_oscillator;
  logic o_coil_a_pos, o_coil_a_neg, o_coil_b_pos, o_coil_b_neg;
  logic o_error_flag1, o_error_flag1_oe, o_error_flag2, o_error_flag2_oe;
  logic o_cmd_valid, o_cmd_room, o_latch_overrun;
  logic [TRQ_W-1:0] o_torque_code;
  logic [RATIO_W-1:0] o_coil_current;
  logic [WORD_W-1:0] o_cmd_data, w, head, shadow = 8'h00;
  logic [WORD_W-1:0] exp_q [$];           // Words still to appear
  int pct [16] = '{0,5,10,15,25,29,38,43,52,60,67,74,80,86,94,100};
  logic [3:0] steps [8] = '{4'hF,4'hE,4'hA,4'hB,4'hC,4'h2,4'h8,4'h3};
  logic [1:0] fx [3] = '{2'b11, 2'b10, 2'b01}; // Flag drive per fault
  int n_fail = 0, samples_checked = 0, cycles = 0;
  wire logic [3:0] ctl = {o_coil_b_drive_on, o_coil_b_direction,
    o_coil_a_drive_on, o_coil_a_direction};
  wire logic [3:0] legs = {o_coil_a_pos, o_coil_a_neg, o_coil_b_pos,
    o_coil_b_neg};
  stepper_cmd_reg stepper_cmd_reg_i (.*);
  host_serial_model host_serial_model_i (.i_clk, .o_serial_clk(i_serial_clk),
    .o_serial_data(i_serial_data), .o_latch(i_latch));
  always #12.5 i_clk = ~i_clk;
  // Hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin n_fail++; test_done(); end
  end
  // Taken words vs oldest note
  always @(posedge i_clk)
    if (!i_rst && i_cmd_ready && o_cmd_valid === 1'b1) begin
      head = exp_q.size() ? exp_q.pop_front() : 8'hxx;
      `CHK("cmd_word", head, o_cmd_data)
    end
  // ============================================================
  // Tasks
  // ============================================================
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Blanked shifts leave the shadow
  task automatic send(input logic [7:0] v);
    host_serial_model_i.send_word(v);
    if (!i_blank) shadow = v;
  endtask
  task automatic latch_word();
    exp_q.push_back(shadow);
    host_serial_model_i.pulse_latch();
  endtask
  task automatic check_ctrl(input logic [7:0] v);
    logic [3:0] c;
    c = {v[4], v[5], v[6], v[7]};
    `CHK("ctrl", v[3:0], ctl)
    `CHK("torque", c, o_torque_code)
    `CHK("ratio", 7'(pct[c]), o_coil_current)
    `CHK("legs", {v[1]&v[0], v[1]&~v[0], v[3]&v[2], v[3]&~v[2]}, legs)
  endtask
  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    void'($urandom(87548));
    repeat (3) @(posedge i_clk);
    i_rst <= 0;
    repeat (8) @(posedge i_clk);
    `CHK("idle", 9'h100, {o_cmd_room, ctl, o_torque_code})
    // Full then half steps, every torque code once
    for (int i = 0; i < 16; i++) begin
      w = {i[0], i[1], i[2], i[3], steps[i % 8]};
      send(w);
      latch_word();
      check_ctrl(w);
      `CHK("cascade", w[7], o_last_shift_stage)
    end
    // Stall: two random words fill buffer
    i_cmd_ready <= 0;
    repeat (2) begin
      w = 8'($urandom);
      send(w);
      latch_word();
      check_ctrl(w);
    end
    `CHK("full", 3'h0, {o_cmd_room, o_latch_overrun, o_error_flag1})
    i_cmd_ready <= 1;
    repeat (4) @(posedge i_clk);
    `CHK("drained", 1'b0, o_cmd_valid)
    // Blanking forces low, blocks shifting
    i_blank <= 1;
    repeat (6) @(posedge i_clk);
    `CHK("blanked", 8'h00, {ctl, o_torque_code})
    send(~w);
    i_blank <= 0;
    repeat (6) @(posedge i_clk);
    check_ctrl(w);
    latch_word();
    check_ctrl(w);
    // Clear empties both registers
    i_register_clear_n <= 0;
    repeat (6) @(posedge i_clk);
    `CHK("cleared", 10'h000, {o_error_flag2, o_last_shift_stage, ctl, o_torque_code})
    i_register_clear_n <= 1;
    shadow = 8'h00;
    repeat (4) @(posedge i_clk);
    latch_word();
    check_ctrl(8'h00);
    // Each fault kind, then sleep releases it
    for (int f = 0; f < 3; f++) begin
      {i_fault_thermal, i_fault_overcur, i_fault_open} <= 3'(4 >> f);
      repeat (6) @(posedge i_clk);
      `CHK("fault", fx[f], {o_error_flag1_oe, o_error_flag2_oe})
      {i_fault_thermal, i_fault_overcur, i_fault_open} <= 3'b000;
      i_sleep_n <= 0;
      repeat (6) @(posedge i_clk);
      `CHK("sleep", 3'b000, {o_chop_oscillator, o_error_flag1_oe, o_error_flag2_oe})
      i_sleep_n <= 1;
      repeat (6) @(posedge i_clk);
      `CHK("awake", 1'b1, o_chop_oscillator)
    end
    test_done();
  end
endmodule // stepper_cmd_reg_tb
